/* vlan_port_tag_classifier_defines.svh */
// Offsets, field positions, reset values and tag identifiers of the VLAN port block
`ifndef VLAN_PORT_TAG_CLASSIFIER_DEFINES_SVH
`define VLAN_PORT_TAG_CLASSIFIER_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define VLAN_OFS_PORT_CFG 8'h00
`define VLAN_OFS_DEFAULT_VID 8'h04
`define VLAN_OFS_CUSTOM_ETYPE 8'h08
`define VLAN_OFS_VLAN_SEL 8'h0C
`define VLAN_OFS_VLAN_MEMBER 8'h10
`define VLAN_OFS_STATUS 8'h14

// ==========================================================================
// Port configuration field positions
`define VLAN_CFG_MODE_LSB 0
`define VLAN_CFG_TYPE_LSB 2
`define VLAN_CFG_FILTER_BIT 4
`define VLAN_CFG_ACCEPT_LSB 5
`define VLAN_CFG_EGRESS_LSB 7

// ==========================================================================
// Membership word and status field positions
`define VLAN_MEM_ALLOWED_BIT 0
`define VLAN_MEM_FORBID_BIT 1
`define VLAN_STAT_CONFLICT_BIT 0

// ==========================================================================
// Reset values and tag identifiers
`define VLAN_PORT_DEFAULT_VLAN_ID_RESET 12'h001
`define VLAN_CUSTOM_ETYPE_RESET 16'h88A8
`define VLAN_TPID_CTAG 16'h8100
`define VLAN_TPID_STAG 16'h88A8
`define VLAN_VID_NONE 12'h000

`endif

/* vlan_pkg.sv */
// Types shared by the VLAN port block
package vlan_pkg;

   // =======================================================================
   // Port operating modes
   typedef enum logic [1:0] {MODE_ACCESS, MODE_TRUNK, MODE_HYBRID} mode_t;

   // =======================================================================
   // Tag awareness of the port
   typedef enum logic [1:0] {PT_UNAWARE, PT_CPORT, PT_SPORT, PT_SCUSTOM} ptype_t;

   // =======================================================================
   // Ingress frame acceptance
   typedef enum logic [1:0] {ACC_ALL, ACC_TAGGED, ACC_UNTAGGED} accept_t;

   // =======================================================================
   // Egress tagging policy
   typedef enum logic [1:0] {EG_STRIP_PORT_DEFAULT_VLAN_ID, EG_TAG_ALL, EG_UNTAG_ALL} egress_t;

endpackage

/* vlan_port_tag_classifier.sv */
// Per-port VLAN classification, acceptance, filtering and egress tagging
//
// Behaviour
// - Unaware port: default VLAN, tag kept
// - C-port classifies 0x8100 tags by VID
// - S-port classifies 0x8100 or 0x88A8 tags
// - Custom port classifies 0x8100 or custom ethertype
// - Aware port: untagged, priority-tagged get default VLAN
// - VID zero means priority tagged
// - Inserted tag kind follows port type
// - Filtering forced on unless hybrid
// - Filtering on drops non-member VLAN frames
// - Filtering off passes non-member frames
// - Never transmit on non-member VLAN
// - Acceptance defaults to tagged and untagged
// - Tagged-only drops untagged frames
// - Untagged-only drops VLAN-tagged frames
// - Strip default VLAN, tag others
// - Tag-all tags all on aware ports; untag-all strips all
// - Egress policy fully selectable in hybrid; trunk can select tag-all
// - Trunk tag-all accepts only tagged frames
// - Access port accepts untagged and C-tagged
// - Allowed set defaults 1-4095; empty means none
// - Forbidden set blocks every membership
// - Dynamic registration on forbidden flags conflict
// - Forward only on member ports
// - Default VLAN 1 to 4095, resets 1
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "vlan_port_tag_classifier_defines.svh"

module vlan_port_tag_classifier #(
   parameter int VID_W = 12,
   parameter int VLAN_COUNT = 4096
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Ingress frame header from the port
   input wire logic rxValid,
   input wire logic rxTagged,
   input wire logic [15:0] rxTpid,
   input wire logic [VID_W-1:0] rxVid,
   // Ingress verdict to the forwarding engine
   output logic rxDoneValid,
   output logic [VID_W-1:0] rxClassVid,
   output logic rxAccept,
   output logic rxStripTag,
   output logic rxDropAccept,
   output logic rxDropFilter,
   // Egress request from the forwarding engine
   input wire logic txValid,
   input wire logic [VID_W-1:0] txVid,
   // Egress decision to the port
   output logic txDoneValid,
   output logic txSend,
   output logic txAddTag,
   output logic [15:0] txTpid,
   output logic [VID_W-1:0] txTagVid,
   // Dynamic VLAN user registrations
   input wire logic dynValid,
   input wire logic dynAdd,
   input wire logic [VID_W-1:0] dynVid,
   // Conflict indication
   output logic conflictFlag
);

   // =======================================================================
   // Membership of one VLAN from its stored bits
   function automatic logic memberOf(
      input vlan_pkg::mode_t m,
      input logic [VID_W-1:0] vid,
      input logic [VID_W-1:0] port_default_vlan_id,
      input logic allowedBit,
      input logic forbidBit,
      input logic dynBit
   );
      logic staticMember;
      begin
         staticMember = (m == vlan_pkg::MODE_ACCESS) ? (vid == port_default_vlan_id) : allowedBit;
         memberOf = (vid != `VLAN_VID_NONE) & (staticMember | dynBit) & ~forbidBit;
      end
   endfunction

   // =======================================================================
   // Storage
   logic [1:0] cfgMode_r;
   logic [1:0] cfgType_r;
   logic cfgFilter_r;
   logic [1:0] cfgAccept_r;
   logic [1:0] cfgEgress_r;
   logic [VID_W-1:0] port_default_vlan_id_r;
   logic [15:0] customEtype_r;
   logic [VID_W-1:0] vlanSel_r;
   logic [VLAN_COUNT-1:0] allowedSet_r;
   logic [VLAN_COUNT-1:0] forbidSet_r;
   logic [VLAN_COUNT-1:0] dynSet_r;
   logic conflict_r;
   logic [VID_W-1:0] conflictVid_r;
   logic dphWr_r;
   logic dphRd_r;
   logic [7:0] dphAddr_r;
   logic rdStage_r;
   logic [31:0] hrdata_r;

   // =======================================================================
   // Effective port settings
   vlan_pkg::mode_t portMode;
   vlan_pkg::ptype_t effType;
   vlan_pkg::accept_t effAccept;
   vlan_pkg::egress_t effEgress;
   vlan_pkg::egress_t cfgEgress;
   vlan_pkg::accept_t cfgAccept;
   logic isHybrid;
   logic isTrunk;
   logic effFilter;

   always_comb
   begin
      unique case (cfgMode_r)
         2'h1: portMode = vlan_pkg::MODE_TRUNK;
         2'h2: portMode = vlan_pkg::MODE_HYBRID;
         default: portMode = vlan_pkg::MODE_ACCESS;
      endcase
      unique case (cfgAccept_r)
         2'h1: cfgAccept = vlan_pkg::ACC_TAGGED;
         2'h2: cfgAccept = vlan_pkg::ACC_UNTAGGED;
         default: cfgAccept = vlan_pkg::ACC_ALL;
      endcase
      unique case (cfgEgress_r)
         2'h1: cfgEgress = vlan_pkg::EG_TAG_ALL;
         2'h2: cfgEgress = vlan_pkg::EG_UNTAG_ALL;
         default: cfgEgress = vlan_pkg::EG_STRIP_PORT_DEFAULT_VLAN_ID;
      endcase
   end

   assign isHybrid = (portMode == vlan_pkg::MODE_HYBRID);
   assign isTrunk = (portMode == vlan_pkg::MODE_TRUNK);
   assign effFilter = ~isHybrid | cfgFilter_r;
   assign effType = isHybrid ? vlan_pkg::ptype_t'(cfgType_r) : vlan_pkg::PT_CPORT;
   assign effEgress = isHybrid ? cfgEgress :
      ((isTrunk && cfgEgress == vlan_pkg::EG_TAG_ALL) ? vlan_pkg::EG_TAG_ALL :
      vlan_pkg::EG_STRIP_PORT_DEFAULT_VLAN_ID);
   assign effAccept = isHybrid ? cfgAccept :
      ((isTrunk && effEgress == vlan_pkg::EG_TAG_ALL) ? vlan_pkg::ACC_TAGGED :
      vlan_pkg::ACC_ALL);

   // =======================================================================
   // Ingress classification
   logic tpidC;
   logic tpidS;
   logic tpidX;
   logic tagKnown;
   logic prioTag;
   logic vlanTagged;
   logic [VID_W-1:0] classVid;
   logic acceptOk;
   logic ingMember;
   logic filterOk;

   assign tpidC = (rxTpid == `VLAN_TPID_CTAG);
   assign tpidS = (rxTpid == `VLAN_TPID_STAG);
   assign tpidX = (rxTpid == customEtype_r);

   always_comb
   begin
      unique case (effType)
         vlan_pkg::PT_UNAWARE: tagKnown = 1'b0;
         vlan_pkg::PT_CPORT: tagKnown = rxTagged & tpidC;
         vlan_pkg::PT_SPORT: tagKnown = rxTagged & (tpidC | tpidS);
         vlan_pkg::PT_SCUSTOM: tagKnown = rxTagged & (tpidC | tpidX);
      endcase
   end

   assign prioTag = tagKnown & (rxVid == `VLAN_VID_NONE);
   assign vlanTagged = tagKnown & ~prioTag;
   assign classVid = vlanTagged ? rxVid : port_default_vlan_id_r;

   // Acceptance is judged on the classified frame
   always_comb
   begin
      unique case (effAccept)
         vlan_pkg::ACC_ALL: acceptOk = 1'b1;
         vlan_pkg::ACC_TAGGED: acceptOk = vlanTagged;
         vlan_pkg::ACC_UNTAGGED: acceptOk = ~vlanTagged;
         default: acceptOk = 1'b1;
      endcase
   end

   assign ingMember = memberOf(portMode, classVid, port_default_vlan_id_r, allowedSet_r[classVid],
      forbidSet_r[classVid], dynSet_r[classVid]);
   assign filterOk = ~effFilter | ingMember;

   // =======================================================================
   // Ingress verdict register
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         rxDoneValid <= 1'b0;
         rxClassVid <= `VLAN_VID_NONE;
         rxAccept <= 1'b0;
         rxStripTag <= 1'b0;
         rxDropAccept <= 1'b0;
         rxDropFilter <= 1'b0;
      end
      else
      begin
         rxDoneValid <= rxValid;
         if (rxValid)
         begin
            rxClassVid <= classVid;
            rxAccept <= acceptOk & filterOk;
            rxStripTag <= tagKnown;
            rxDropAccept <= ~acceptOk;
            rxDropFilter <= acceptOk & ~filterOk;
         end
      end
   end

   // =======================================================================
   // Egress tagging decision
   logic egMember;
   logic egTag;
   logic [15:0] egTpid;

   assign egMember = memberOf(portMode, txVid, port_default_vlan_id_r, allowedSet_r[txVid],
      forbidSet_r[txVid], dynSet_r[txVid]);

   always_comb
   begin
      unique case (effEgress)
         vlan_pkg::EG_STRIP_PORT_DEFAULT_VLAN_ID: egTag = (txVid != port_default_vlan_id_r);
         vlan_pkg::EG_TAG_ALL: egTag = 1'b1;
         vlan_pkg::EG_UNTAG_ALL: egTag = 1'b0;
         default: egTag = 1'b0;
      endcase
      unique case (effType)
         vlan_pkg::PT_UNAWARE: egTpid = `VLAN_TPID_CTAG;
         vlan_pkg::PT_CPORT: egTpid = `VLAN_TPID_CTAG;
         vlan_pkg::PT_SPORT: egTpid = `VLAN_TPID_STAG;
         vlan_pkg::PT_SCUSTOM: egTpid = customEtype_r;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         txDoneValid <= 1'b0;
         txSend <= 1'b0;
         txAddTag <= 1'b0;
         txTpid <= `VLAN_TPID_CTAG;
         txTagVid <= `VLAN_VID_NONE;
      end
      else
      begin
         txDoneValid <= txValid;
         if (txValid)
         begin
            txSend <= egMember;
            txAddTag <= egMember & egTag & (effType != vlan_pkg::PT_UNAWARE);
            txTpid <= egTpid;
            txTagVid <= txVid;
         end
      end
   end

   // =======================================================================
   // AHB-Lite slave: zero-wait writes, one-wait reads
   logic addrAccept;
   logic wrCfg;
   logic wrPvid;
   logic wrCustom;
   logic wrSel;
   logic wrMember;
   logic wrStatus;
   logic [31:0] rdMux;
   logic selMember;

   assign addrAccept = hsel & htrans[1] & hready;
   assign hreadyout = ~(dphRd_r & ~rdStage_r);
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   assign wrCfg = dphWr_r & (dphAddr_r == `VLAN_OFS_PORT_CFG);
   assign wrPvid = dphWr_r & (dphAddr_r == `VLAN_OFS_DEFAULT_VID);
   assign wrCustom = dphWr_r & (dphAddr_r == `VLAN_OFS_CUSTOM_ETYPE);
   assign wrSel = dphWr_r & (dphAddr_r == `VLAN_OFS_VLAN_SEL);
   assign wrMember = dphWr_r & (dphAddr_r == `VLAN_OFS_VLAN_MEMBER);
   assign wrStatus = dphWr_r & (dphAddr_r == `VLAN_OFS_STATUS);

   assign selMember = memberOf(portMode, vlanSel_r, port_default_vlan_id_r, allowedSet_r[vlanSel_r],
      forbidSet_r[vlanSel_r], dynSet_r[vlanSel_r]);

   assign rdMux =
      (dphAddr_r == `VLAN_OFS_PORT_CFG) ?
         {23'h000000, cfgEgress_r, cfgAccept_r, cfgFilter_r, cfgType_r, cfgMode_r} :
      (dphAddr_r == `VLAN_OFS_DEFAULT_VID) ? {20'h00000, port_default_vlan_id_r} :
      (dphAddr_r == `VLAN_OFS_CUSTOM_ETYPE) ? {16'h0000, customEtype_r} :
      (dphAddr_r == `VLAN_OFS_VLAN_SEL) ? {20'h00000, vlanSel_r} :
      (dphAddr_r == `VLAN_OFS_VLAN_MEMBER) ?
         {28'h0000000, selMember, dynSet_r[vlanSel_r], forbidSet_r[vlanSel_r],
         allowedSet_r[vlanSel_r]} :
      (dphAddr_r == `VLAN_OFS_STATUS) ?
         {4'h0, conflictVid_r, 8'h00, effType, effEgress, effAccept, effFilter, conflict_r} :
      32'h00000000;

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         dphWr_r <= 1'b0;
         dphRd_r <= 1'b0;
         dphAddr_r <= 8'h00;
         rdStage_r <= 1'b0;
         hrdata_r <= 32'h00000000;
      end
      else
      begin
         if (hready)
         begin
            dphWr_r <= addrAccept & hwrite;
            dphRd_r <= addrAccept & ~hwrite;
            dphAddr_r <= haddr[7:0];
         end
         rdStage_r <= dphRd_r & ~rdStage_r;
         if (dphRd_r & ~rdStage_r)
            hrdata_r <= rdMux;
      end
   end

   // =======================================================================
   // Port configuration registers
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         cfgMode_r <= 2'h0;
         cfgType_r <= 2'h1;
         cfgFilter_r <= 1'b1;
         cfgAccept_r <= 2'h0;
         cfgEgress_r <= 2'h0;
         port_default_vlan_id_r <= `VLAN_PORT_DEFAULT_VLAN_ID_RESET;
         customEtype_r <= `VLAN_CUSTOM_ETYPE_RESET;
         vlanSel_r <= `VLAN_VID_NONE;
      end
      else
      begin
         if (wrCfg)
         begin
            cfgMode_r <= hwdata[`VLAN_CFG_MODE_LSB +: 2];
            cfgType_r <= hwdata[`VLAN_CFG_TYPE_LSB +: 2];
            cfgFilter_r <= hwdata[`VLAN_CFG_FILTER_BIT];
            cfgAccept_r <= hwdata[`VLAN_CFG_ACCEPT_LSB +: 2];
            cfgEgress_r <= hwdata[`VLAN_CFG_EGRESS_LSB +: 2];
         end
         if (wrPvid && hwdata[VID_W-1:0] != `VLAN_VID_NONE)
            port_default_vlan_id_r <= hwdata[VID_W-1:0];
         if (wrCustom)
            customEtype_r <= hwdata[15:0];
         if (wrSel)
            vlanSel_r <= hwdata[VID_W-1:0];
      end
   end

   // =======================================================================
   // Membership sets and dynamic registrations
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         allowedSet_r <= {{(VLAN_COUNT-1){1'b1}}, 1'b0};
         forbidSet_r <= '0;
         dynSet_r <= '0;
      end
      else
      begin
         if (wrMember)
         begin
            allowedSet_r[vlanSel_r] <= hwdata[`VLAN_MEM_ALLOWED_BIT];
            forbidSet_r[vlanSel_r] <= hwdata[`VLAN_MEM_FORBID_BIT];
         end
         if (dynValid)
            dynSet_r[dynVid] <= dynAdd;
      end
   end

   // =======================================================================
   // Conflict flag: hardware set wins over software clear
   logic conflictSet;

   assign conflictSet = dynValid & dynAdd & forbidSet_r[dynVid];
   assign conflictFlag = conflict_r;

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         conflict_r <= 1'b0;
         conflictVid_r <= `VLAN_VID_NONE;
      end
      else
      begin
         if (conflictSet)
         begin
            conflict_r <= 1'b1;
            conflictVid_r <= dynVid;
         end
         else if (wrStatus && hwdata[`VLAN_STAT_CONFLICT_BIT])
            conflict_r <= 1'b0;
      end
   end

endmodule

/* vlan_port_tag_classifier_props.sv */
// Concurrent checks on the ports of the VLAN port block
`timescale 1ns/10ps
module vlan_port_tag_classifier_props #(
   parameter int VID_W = 12,
   parameter int VLAN_COUNT = 4096
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Bus
   input wire logic hsel,
   input wire logic hwrite,
   // Ingress
   input wire logic rxValid,
   input wire logic rxTagged,
   input wire logic rxDoneValid,
   input wire logic [VID_W-1:0] rxClassVid,
   input wire logic rxAccept,
   input wire logic rxStripTag,
   input wire logic rxDropAccept,
   input wire logic rxDropFilter,
   // Egress
   input wire logic txValid,
   input wire logic [VID_W-1:0] txVid,
   input wire logic txDoneValid,
   input wire logic txSend,
   input wire logic txAddTag,
   input wire logic [VID_W-1:0] txTagVid,
   // Dynamic users
   input wire logic dynValid,
   input wire logic dynAdd,
   input wire logic conflictFlag
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   // =====================================================================
   // Verdicts
   property p_rx_answer;
      rxValid |=> rxDoneValid;
   endproperty
   a_rx_answer: assert property (p_rx_answer) else $error("rx verdict missing");
   property p_tx_answer;
      txValid |=> txDoneValid;
   endproperty
   a_tx_answer: assert property (p_tx_answer) else $error("tx decision missing");
   property p_one_verdict;
      rxDoneValid |-> $onehot({rxAccept, rxDropAccept, rxDropFilter});
   endproperty
   a_one_verdict: assert property (p_one_verdict) else $error("rx verdict ambiguous");
   property p_strip_needs_tag;
      rxDoneValid && !$past(rxTagged) |-> !rxStripTag;
   endproperty
   a_strip_needs_tag: assert property (p_strip_needs_tag) else $error("strip on untagged");
   property p_class_nonzero;
      rxDoneValid |-> rxClassVid != '0;
   endproperty
   a_class_nonzero: assert property (p_class_nonzero) else $error("classified to VID 0");
   property p_tag_only_send;
      txDoneValid && txAddTag |-> txSend && txTagVid == $past(txVid);
   endproperty
   a_tag_only_send: assert property (p_tag_only_send) else $error("bad inserted tag");

   // =====================================================================
   // Conflict flag
   property p_conflict_set;
      $rose(conflictFlag) |-> $past(dynValid) && $past(dynAdd);
   endproperty
   a_conflict_set: assert property (p_conflict_set) else $error("conflict without add");
   property p_conflict_clear;
      $fell(conflictFlag) |-> $past(hsel, 2) && $past(hwrite, 2);
   endproperty
   a_conflict_clear: assert property (p_conflict_clear) else $error("conflict lost");

   c_filter_drop: cover property (rxDoneValid && rxDropFilter);
   c_tag_added: cover property (txDoneValid && txAddTag);
   c_conflict: cover property ($rose(conflictFlag));
endmodule

bind vlan_port_tag_classifier vlan_port_tag_classifier_props #(.VID_W(VID_W), .VLAN_COUNT(VLAN_COUNT))
   uProps (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .hwrite(hwrite), .rxValid(rxValid),
   .rxTagged(rxTagged), .rxDoneValid(rxDoneValid), .rxClassVid(rxClassVid), .rxAccept(rxAccept),
   .rxStripTag(rxStripTag), .rxDropAccept(rxDropAccept), .rxDropFilter(rxDropFilter),
   .txValid(txValid), .txVid(txVid), .txDoneValid(txDoneValid), .txSend(txSend),
   .txAddTag(txAddTag), .txTagVid(txTagVid), .dynValid(dynValid), .dynAdd(dynAdd),
   .conflictFlag(conflictFlag));

/* vlan_frame_source.sv */
// Ingress header source standing in for the Ethernet port
`timescale 1ns/10ps
module vlan_frame_source (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Request from the bench
   input wire logic go,
   input wire logic goTagged,
   input wire logic [15:0] goTpid,
   input wire logic [11:0] goVid,
   // Header to the block
   output logic rxValid,
   output logic rxTagged,
   output logic [15:0] rxTpid,
   output logic [11:0] rxVid
);
   // Between headers the fields flip every cycle, so nothing stale looks valid
   always_ff @(posedge ref_clk)
   begin
      rxValid <= go && !sys_rst;
      rxTagged <= (go || sys_rst) ? goTagged : ~rxTagged;
      rxTpid <= (go || sys_rst) ? goTpid : ~rxTpid;
      rxVid <= (go || sys_rst) ? goVid : ~rxVid;
   end
endmodule

/* vlan_port_tag_classifier_tb.sv */
// Self-checking bench for the VLAN port block
`timescale 1ns/10ps
module vlan_port_tag_classifier_tb;
   logic ref_clk, sys_rst, hsel, hwrite, hreadyout, hresp, rxDoneValid, rxAccept, rxStripTag;
   logic rxDropAccept, rxDropFilter, txValid, txDoneValid, txSend, txAddTag, dynValid, dynAdd;
   logic rxValid, rxTagged, srcGo, srcTagged, conflictFlag;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rdq, te, tm;
   logic [15:0] rxTpid, txTpid, srcTpid;
   logic [11:0] rxVid, rxClassVid, txVid, txTagVid, dynVid, srcVid, rv, rv2;
   logic [15:0] tpTx [4];
   logic [15:0] tpRx [4];
   logic [31:0] rxQ [$];
   logic [31:0] txQ [$];
   int err_total, compares;

   initial
   begin
      ref_clk = 1'h0;
      forever #10 ref_clk = ~ref_clk;
   end

   vlan_port_tag_classifier uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxValid(rxValid),
      .rxTagged(rxTagged), .rxTpid(rxTpid), .rxVid(rxVid), .rxDoneValid(rxDoneValid),
      .rxClassVid(rxClassVid), .rxAccept(rxAccept), .rxStripTag(rxStripTag),
      .rxDropAccept(rxDropAccept), .rxDropFilter(rxDropFilter), .txValid(txValid), .txVid(txVid),
      .txDoneValid(txDoneValid), .txSend(txSend), .txAddTag(txAddTag), .txTpid(txTpid),
      .txTagVid(txTagVid), .dynValid(dynValid), .dynAdd(dynAdd), .dynVid(dynVid),
      .conflictFlag(conflictFlag));
   vlan_frame_source uSrc (.ref_clk(ref_clk), .sys_rst(sys_rst), .go(srcGo), .goTagged(srcTagged),
      .goTpid(srcTpid), .goVid(srcVid), .rxValid(rxValid), .rxTagged(rxTagged), .rxTpid(rxTpid),
      .rxVid(rxVid));

   // ======================================================================
   // Comparison, bus and stimulus tasks
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'h1);
      rdq = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      ahb(1'h0, a, 32'h0);
      check("hrdata", rdq, e);
      check("hresp", {31'h0, hresp}, 32'h0);
   endtask
   task automatic cfg(input logic [1:0] m, t, input logic f, input logic [1:0] ac, eg);
      ahb(1'h1, 8'h00, {23'h0, eg, ac, f, t, m});
   endtask
   task automatic rx(input logic tg, input logic [15:0] tp, input logic [11:0] v, ev,
      input logic st, input int res);
      rxQ.push_back({16'h0, ev, st, res == 0, res == 1, res == 2});
      srcGo <= 1'h1;
      srcTagged <= tg;
      srcTpid <= tp;
      srcVid <= v;
      @(posedge ref_clk);
      srcGo <= 1'h0;
      @(posedge ref_clk);
   endtask
   task automatic tx(input logic [11:0] v, input logic s, ad, input logic [15:0] tp);
      txQ.push_back({2'h0, s, ad, tp, v});
      txValid <= 1'h1;
      txVid <= v;
      @(posedge ref_clk);
      txValid <= 1'h0;
      txVid <= ~v;
      @(posedge ref_clk);
   endtask
   task automatic dyn(input logic ad, input logic [11:0] v);
      dynValid <= 1'h1;
      dynAdd <= ad;
      dynVid <= v;
      @(posedge ref_clk);
      dynValid <= 1'h0;
      @(posedge ref_clk);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ======================================================================
   // Result watcher
   always @(posedge ref_clk)
   begin
      if (rxDoneValid === 1'h1)
         check("rx verdict", {16'h0, rxClassVid, rxStripTag, rxAccept, rxDropAccept, rxDropFilter},
            rxQ.size() ? rxQ.pop_front() : 32'hFFFFFFFF);
      if (txDoneValid === 1'h1)
      begin
         te = txQ.size() ? txQ.pop_front() : 32'hFFFFFFFF;
         tm = te[28] ? 32'hFFFFFFFF : 32'h30000000;
         check("tx decision", {2'h0, txSend, txAddTag, txTpid, txTagVid} & tm, te & tm);
      end
   end

   // ======================================================================
   // Watchdog, some thirty times the expected run
   initial
   begin
      repeat (5000) @(posedge ref_clk);
      err_total++;
      end_of_test();
   end

   // ======================================================================
   // Main sequence
   initial
   begin
      {hsel, hwrite, txValid, dynValid, dynAdd, srcGo, srcTagged} = 7'h00;
      htrans = 2'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      {txVid, dynVid, srcVid, srcTpid} = 52'h0;
      sys_rst = 1'h1;
      err_total = 0;
      compares = 0;
      tpTx = '{16'h0000, 16'h8100, 16'h88A8, 16'h9100};
      tpRx = '{16'h8100, 16'h88A8, 16'h88A8, 16'h9100};
      void'($urandom(6245));
      rv = 12'($urandom_range(4094, 2048));
      rv2 = 12'($urandom_range(2047, 2));
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'h0;
      rd(8'h00, 32'h00000014);
      rd(8'h04, 32'h00000001);
      rd(8'h14, 32'h00000042);
      rd(8'h20, 32'h00000000);
      ahb(1'h1, 8'h04, 32'h00000000);
      rd(8'h04, 32'h00000001);
      rx(1'h0, 16'h8100, rv, 12'h001, 1'h0, 0);
      rx(1'h1, 16'h8100, rv, rv, 1'h1, 2);
      rx(1'h1, 16'h8100, 12'h000, 12'h001, 1'h1, 0);
      tx(12'h001, 1'h1, 1'h0, 16'h0);
      tx(rv, 1'h0, 1'h0, 16'h0);
      ahb(1'h1, 8'h08, 32'h00009100);
      for (int t = 0; t < 4; t++)
      begin
         cfg(2'h2, 2'(t), 1'h0, 2'h0, 2'h1);
         rx(1'h1, 16'h8100, rv, (t == 0) ? 12'h001 : rv, t != 0, 0);
         rx(1'h1, tpRx[t], rv, (t < 2) ? 12'h001 : rv, t >= 2, 0);
         tx(rv, 1'h1, t != 0, tpTx[t]);
      end
      ahb(1'h1, 8'h0C, {20'h0, rv});
      ahb(1'h1, 8'h10, 32'h3);
      rx(1'h1, 16'h8100, rv, rv, 1'h1, 0);
      tx(rv, 1'h0, 1'h0, 16'h0);
      dyn(1'h1, rv);
      check("conflictFlag", {31'h0, conflictFlag}, 32'h1);
      rd(8'h10, 32'h00000007);
      ahb(1'h1, 8'h14, 32'h1);
      @(posedge ref_clk);
      check("conflictFlag", {31'h0, conflictFlag}, 32'h0);
      dyn(1'h0, rv);
      rd(8'h10, 32'h00000003);
      cfg(2'h2, 2'h1, 1'h1, 2'h0, 2'h0);
      ahb(1'h1, 8'h0C, {20'h0, rv2});
      ahb(1'h1, 8'h10, 32'h0);
      rx(1'h1, 16'h8100, rv2, rv2, 1'h1, 2);
      cfg(2'h2, 2'h1, 1'h0, 2'h1, 2'h2);
      rx(1'h0, 16'h8100, rv, 12'h001, 1'h0, 1);
      tx(12'hFFF, 1'h1, 1'h0, 16'h0);
      cfg(2'h2, 2'h1, 1'h0, 2'h2, 2'h0);
      rx(1'h1, 16'h8100, 12'hFFF, 12'hFFF, 1'h1, 1);
      rx(1'h1, 16'h8100, 12'h000, 12'h001, 1'h1, 0);
      tx(12'hFFF, 1'h1, 1'h1, 16'h8100);
      cfg(2'h1, 2'h0, 1'h0, 2'h2, 2'h1);
      rx(1'h0, 16'h8100, rv, 12'h001, 1'h0, 1);
      rx(1'h1, 16'h8100, 12'hFFF, 12'hFFF, 1'h1, 0);
      cfg(2'h1, 2'h2, 1'h0, 2'h0, 2'h2);
      rx(1'h1, 16'h8100, rv, rv, 1'h1, 2);
      rx(1'h1, 16'h88A8, 12'hFFF, 12'h001, 1'h0, 0);
      tx(12'h001, 1'h1, 1'h0, 16'h0);
      tx(12'hFFF, 1'h1, 1'h1, 16'h8100);
      cfg(2'h0, 2'h0, 1'h0, 2'h1, 2'h1);
      rx(1'h0, 16'h8100, rv, 12'h001, 1'h0, 0);
      tx(12'hFFF, 1'h0, 1'h0, 16'h0);
      repeat (4) @(posedge ref_clk);
      check("queues", 32'(rxQ.size() + txQ.size()), 32'h0);
      end_of_test();
   end
endmodule
